/* dv/bal_button_tb.sv */
// Testbench: register access, button actions and key lock of bal_button
`timescale 1ns/1ps
`default_nettype none

module bal_button_tb;
  import bal_pkg::*;

  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        button;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, dark, dark1, dark2, light1, light2, locked;
  logic [15:0] offset;
  logic        go = 1'b0;
  int          err_count = 0;
  int          num_checks = 0;
  int          n_dark = 0;
  int          n_d1 = 0;
  int          n_d2 = 0;

  // ==========================================================================
  // Clock, design and operator
  always #2.5 clock = ~clock;

  bal_button uut (.i_clock(clock), .i_srst(srst), .i_button(button), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_dark_reference_capture(dark), .o_dark_reference_capture_ch1(dark1),
    .o_dark_reference_capture_ch2(dark2), .o_offset_active(offset),
    .o_light_ch1(light1), .o_light_ch2(light2), .o_locked(locked));

  // Short hold: the ms timer is far too slow to reach the long range here
  bal_press_model op (.i_clock(clock), .i_go(go), .i_hold(16'd20), .o_button(button));

  // Strobe counters, so a missed or doubled pulse shows up
  always @(posedge clock) begin
    if (dark === 1'b1) n_dark++;
    if (dark1 === 1'b1) n_d1++;
    if (dark2 === 1'b1) n_d2++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for ready as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eer);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, eer});
  endtask : rd_chk

  function automatic logic [1:0] dlt(input int now, input int base);
    return 2'(now - base);
  endfunction : dlt

  // Set config, press once, compare strobe counts, lock and levels
  task automatic act(input logic [31:0] cfg, input logic [31:0] exp);
    int b0, b1, b2;
    wr(ADDR_CONFIG, cfg);
    b0 = n_dark;
    b1 = n_d1;
    b2 = n_d2;
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (60) @(posedge clock);
    chk({2'h0, dlt(n_d2, b2), 2'h0, dlt(n_d1, b1), 2'h0, dlt(n_dark, b0), 1'b0, locked,
         light2, light1, offset}, exp);
  endtask : act

  // ==========================================================================
  // Scenarios
  task automatic s_regs();
    rd_chk(ADDR_CONFIG, CONFIG_RST, 1'b0);
    rd_chk(ADDR_LOCK_SEC, LOCK_SEC_RST, 1'b0);
    rd_chk(ADDR_SIGSEL, SIGSEL_RST, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0003_0000, 1'b0);
    wr(ADDR_CONFIG, 32'hffff_ffff);
    rd_chk(ADDR_CONFIG, 32'h0000_13ff, 1'b0);
    wr(ADDR_SIGSEL, 32'hffff_ffff);
    rd_chk(ADDR_SIGSEL, 32'h8000_ffff, 1'b0);
    wr(8'h10, 32'h1234_5678);
    rd_chk(8'h10, 32'h0, 1'b1);
    wr(ADDR_SIGSEL, SIGSEL_RST);
  endtask : s_regs

  task automatic s_single();
    act(32'h0000_0000, 32'h0003_0000);
    act(32'h0000_0001, 32'h0013_0000);
    act(32'h0000_0002, 32'h0003_0000);
    act(32'h0000_0006, 32'h0002_0000);
    act(32'h0000_0006, 32'h0003_0000);
    act(32'h0000_0009, 32'h0003_0000);
  endtask : s_single

  task automatic s_dual();
    act(32'h0000_1002, 32'h0103_0000);
    act(32'h0000_1003, 32'h1003_0000);
    act(32'h0000_1007, 32'h0002_0000);
    act(32'h0000_1008, 32'h0000_0000);
    act(32'h0000_1006, 32'h0003_0000);
  endtask : s_dual

  // Long selector set to dark: a short press must not run it
  task automatic s_offset();
    wr(ADDR_SIGSEL, 32'h0000_0005);
    act(32'h0000_0014, 32'h0003_0005);
    wr(ADDR_SIGSEL, 32'h8000_0000);
    act(32'h0000_0014, 32'h0003_ffff);
    act(32'h0000_0015, 32'h0003_0000);
  endtask : s_offset

  task automatic s_lock();
    act(32'h0000_0206, 32'h0002_0000);
    wr(ADDR_LOCK_SEC, 32'h0);
    act(32'h0000_0206, 32'h0006_0000);
    act(32'h0000_0106, 32'h0006_0000);
    act(32'h0000_0006, 32'h0003_0000);
  endtask : s_lock

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Whole run is about 1200 cycles; this is over thirty times that
  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    s_regs();
    s_single();
    s_dual();
    s_offset();
    s_lock();
    stop_test();
  end
endmodule : bal_button_tb

`default_nettype wire

/* dv/bal_press_model.sv */
// Push button model: holds the pin pressed for one cycle more than the requested number of cycles
`timescale 1ns/1ps
`default_nettype none

module bal_press_model (
  input  wire logic        i_clock,
  input  wire logic        i_go,
  input  wire logic [15:0] i_hold,
  output logic             o_button
);
  logic [15:0] left_r  = 16'h0000;
  logic        press_r = 1'b0;

  // ==========================================================================
  // Operator presses on request and lets go when the hold runs out
  always @(posedge i_clock) begin
    if (i_go) begin
      left_r  <= i_hold;
      press_r <= 1'b1;
    end else if (left_r != 16'h0000) begin
      left_r <= left_r - 16'h0001;
    end else begin
      press_r <= 1'b0;   // Pin low whenever nobody presses
    end
  end

  assign o_button = press_r;
endmodule : bal_press_model

`default_nettype wire

/* rtl/bal_button.sv */
// Module: multifunction button press timing, action dispatch and key lock
// Behaviour
// - Dark action on single-channel unit starts dark reference capture.
// - Dual unit channel-one dark action captures sensor one only.
// - Dual unit channel-two dark action captures sensor two only.
// - Apply action masters only the currently selected signals.
// - Clear action removes mastering from the affected signals.
// - Single unit light action inverts the light source state.
// - Dual unit light actions toggle sensor one or two independently.
// - Selection is all signals or an explicit list, limiting mastering.
// - Lock disabled: presses always act; none action does nothing.
// - Immediate lock ignores presses right from restart.
// - Auto lock accepts presses until configured seconds pass, then locks.
`timescale 1ns/1ps
`default_nettype none

module bal_button (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_button,        // Raw button pin, high = pressed
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_dark_reference_capture,
  output logic             o_dark_reference_capture_ch1,
  output logic             o_dark_reference_capture_ch2,
  output logic      [15:0] o_offset_active,   // Per signal mastering on
  output logic             o_light_ch1,
  output logic             o_light_ch2,
  output logic             o_locked
);
  import bal_pkg::*;

  // ==========================================================================
  // Registers
  logic [31:0] cfg_r, cfg_nxt, lsec_r, lsec_nxt, sig_r, sig_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [2:0]  sync_r, sync_nxt;
  logic        btn_r, btn_nxt;
  bal_state_t  state_r, state_nxt;
  logic [17:0] div_r, div_nxt;
  logic [12:0] press_ms_r, press_ms_nxt;
  logic [9:0]  sec_ms_r, sec_ms_nxt;
  logic [31:0] up_sec_r, up_sec_nxt;
  logic        locked_r, locked_nxt;
  logic        dk_r, dk_nxt, dk1_r, dk1_nxt, dk2_r, dk2_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic        l1_r, l1_nxt, l2_r, l2_nxt;
  logic        tick, press_end, dual, fire;
  logic [15:0] sel_mask;
  bal_action_t act;

  assign dual     = cfg_r[CFG_DUAL_BIT];
  assign tick     = (div_r == 18'(TICK_CYC - 1));
  // Selection: all bit overrides the list
  assign sel_mask = sig_r[SIG_ALL_BIT] ? 16'hffff : sig_r[SIG_W-1:0];

  // ==========================================================================
  // APB slave, one wait-free access; unmapped reads zero with pslverr
  always_comb begin
    cfg_nxt     = cfg_r;
    lsec_nxt    = lsec_r;
    sig_nxt     = sig_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (i_psel && !i_penable) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0;
      unique case (i_paddr)
        ADDR_CONFIG:   prdata_nxt = cfg_r;
        ADDR_LOCK_SEC: prdata_nxt = lsec_r;
        ADDR_SIGSEL:   prdata_nxt = sig_r;
        ADDR_STATUS: begin
          prdata_nxt[ST_MASTER_LSB +: 16] = ofs_r;
          prdata_nxt[ST_LIGHT1_BIT]       = l1_r;
          prdata_nxt[ST_LIGHT2_BIT]       = l2_r;
          prdata_nxt[ST_LOCKED_BIT]       = locked_r;
          prdata_nxt[ST_PRESS_BIT]        = btn_r;
        end
        default:       pslverr_nxt = 1'b1;
      endcase
    end
    // Writes land only at the access edge, so a dropped transfer changes nothing
    if (i_psel && i_penable && pready_r && i_pwrite) begin
      unique case (i_paddr)
        ADDR_CONFIG:   cfg_nxt  = i_pwdata & 32'h0000_13ff;
        ADDR_LOCK_SEC: lsec_nxt = i_pwdata;
        ADDR_SIGSEL:   sig_nxt  = i_pwdata & 32'h8000_ffff;
        default:       ;
      endcase
    end
  end

  // ==========================================================================
  // Millisecond tick, press timer and uptime for auto lock
  always_comb begin
    sync_nxt     = {sync_r[1:0], i_button};  // Three-stage pin synchroniser
    btn_nxt      = (sync_r[1] == sync_r[2]) ? sync_r[2] : btn_r;
    div_nxt      = tick ? 18'h0 : 18'(div_r + 18'h1);
    state_nxt    = state_r;
    press_ms_nxt = press_ms_r;
    sec_ms_nxt   = sec_ms_r;
    up_sec_nxt   = up_sec_r;
    press_end    = 1'b0;
    if (tick) begin
      sec_ms_nxt = (sec_ms_r == 10'(MS_PER_SEC - 1)) ? 10'h0 : 10'(sec_ms_r + 10'h1);
      if (sec_ms_r == 10'(MS_PER_SEC - 1) && up_sec_r != 32'hffff_ffff)
        up_sec_nxt = up_sec_r + 32'h1;
    end
    unique case (state_r)
      ST_IDLE: begin
        press_ms_nxt = 13'h0;
        if (btn_r) state_nxt = ST_PRESS;
      end
      ST_PRESS: begin
        // Saturate beyond 5 s so long holds never wrap back
        if (tick && press_ms_r <= 13'(LONG_MAX_MS)) press_ms_nxt = 13'(press_ms_r + 13'h1);
        if (!btn_r) begin
          press_end = 1'b1;  // Evaluate once, on release
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Lock: none always open, active locked from restart, auto after timeout
  always_comb begin
    unique case (cfg_r[CFG_LOCK_LSB +: 2])
      LOCK_ACTIVE: locked_nxt = 1'b1;
      LOCK_AUTO:   locked_nxt = (up_sec_r >= lsec_r);
      default:     locked_nxt = 1'b0;
    endcase
  end

  // ==========================================================================
  // Action select by duration; over 5 s nothing
  always_comb begin
    act  = ACT_NONE;
    fire = 1'b0;
    if (press_end && !locked_r) begin
      if (press_ms_r < 13'(SHORT_MAX_MS)) begin
        act = bal_action_t'(cfg_r[CFG_SHORT_LSB +: 4]);
      end else if (press_ms_r <= 13'(LONG_MAX_MS)) begin
        act = bal_action_t'(cfg_r[CFG_LONG_LSB +: 4]);
      end
      fire = 1'b1;
    end
  end

  // Action execution, one-cycle capture strobes
  always_comb begin
    dk_nxt  = 1'b0;
    dk1_nxt = 1'b0;
    dk2_nxt = 1'b0;
    ofs_nxt = ofs_r;
    l1_nxt  = l1_r;
    l2_nxt  = l2_r;
    if (fire) begin
      case (act)
        ACT_DARK:     dk_nxt  = 1'b1;
        ACT_DARK_CH1: dk1_nxt = dual;
        ACT_DARK_CH2: dk2_nxt = dual;
        ACT_ZO_APPLY: ofs_nxt = ofs_r | sel_mask;
        ACT_ZO_CLEAR: ofs_nxt = ofs_r & ~sel_mask;
        ACT_LIGHT: begin
          l1_nxt = ~l1_r;
          if (dual) l2_nxt = ~l2_r;
        end
        ACT_LIGHT_C1: if (dual) l1_nxt = ~l1_r;
        ACT_LIGHT_C2: if (dual) l2_nxt = ~l2_r;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cfg_r      <= CONFIG_RST;
      lsec_r     <= LOCK_SEC_RST;
      sig_r      <= SIGSEL_RST;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      sync_r     <= 3'h0;
      btn_r      <= 1'b0;
      state_r    <= ST_IDLE;
      div_r      <= 18'h0;
      press_ms_r <= 13'h0;
      sec_ms_r   <= 10'h0;
      up_sec_r   <= 32'h0;
      locked_r   <= 1'b0;
      dk_r       <= 1'b0;
      dk1_r      <= 1'b0;
      dk2_r      <= 1'b0;
      ofs_r      <= 16'h0;
      l1_r       <= 1'b1;  // Light on after restart
      l2_r       <= 1'b1;
    end else begin
      cfg_r      <= cfg_nxt;
      lsec_r     <= lsec_nxt;
      sig_r      <= sig_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      sync_r     <= sync_nxt;
      btn_r      <= btn_nxt;
      state_r    <= state_nxt;
      div_r      <= div_nxt;
      press_ms_r <= press_ms_nxt;
      sec_ms_r   <= sec_ms_nxt;
      up_sec_r   <= up_sec_nxt;
      locked_r   <= locked_nxt;
      dk_r       <= dk_nxt;
      dk1_r      <= dk1_nxt;
      dk2_r      <= dk2_nxt;
      ofs_r      <= ofs_nxt;
      l1_r       <= l1_nxt;
      l2_r       <= l2_nxt;
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_dark_reference_capture     = dk_r;
  assign o_dark_reference_capture_ch1 = dk1_r;
  assign o_dark_reference_capture_ch2 = dk2_r;
  assign o_offset_active = ofs_r;
  assign o_light_ch1     = l1_r;
  assign o_light_ch2     = l2_r;
  assign o_locked        = locked_r;

  // ==========================================================================
  // Checks
  sequence s_release_locked;
    press_end && locked_r;
  endsequence

  sequence s_apb_setup;
    i_psel && !i_penable;
  endsequence

  a_lock_blocks_all: assert property (@(posedge i_clock) disable iff (i_srst)
    s_release_locked |=> !dk_r && !dk1_r && !dk2_r && $stable(ofs_r) && $stable(l1_r))
    else $error("action fired while locked");
  a_active_lock: assert property (@(posedge i_clock) disable iff (i_srst)
    cfg_r[CFG_LOCK_LSB +: 2] == LOCK_ACTIVE |=> locked_r)
    else $error("immediate lock not set");
  a_none_unlocked: assert property (@(posedge i_clock) disable iff (i_srst)
    cfg_r[CFG_LOCK_LSB +: 2] == LOCK_NONE |=> !locked_r)
    else $error("locked with lock disabled");
  a_auto_lock: assert property (@(posedge i_clock) disable iff (i_srst)
    cfg_r[CFG_LOCK_LSB +: 2] == LOCK_AUTO |=> locked_r == ($past(up_sec_r) >= $past(lsec_r)))
    else $error("auto lock wrong");
  a_over_five: assert property (@(posedge i_clock) disable iff (i_srst)
    press_end && press_ms_r > 13'(LONG_MAX_MS) |=> !dk_r && $stable(ofs_r) && $stable(l1_r))
    else $error("action after overlong press");
  a_dark_single: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_DARK |=> dk_r ##1 !dk_r)
    else $error("dark capture strobe wrong");
  a_dark_ch1: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_DARK_CH1 && dual |=> dk1_r && !dk2_r)
    else $error("channel one capture wrong");
  a_dark_ch2: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_DARK_CH2 && dual |=> dk2_r && !dk1_r)
    else $error("channel two capture wrong");
  a_apply_mask: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_ZO_APPLY |=> (ofs_r & $past(sel_mask)) == $past(sel_mask))
    else $error("apply missed selected signal");
  a_clear_mask: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_ZO_CLEAR |=> (ofs_r & $past(sel_mask)) == 16'h0)
    else $error("clear left signal mastered");
  a_light_toggle: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_LIGHT |=> l1_r != $past(l1_r))
    else $error("light did not toggle");
  a_light_ch2: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_LIGHT_C2 && dual |=> l2_r != $past(l2_r) && $stable(l1_r))
    else $error("channel two light wrong");
  a_short_class: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && press_ms_r < 13'(SHORT_MAX_MS) |-> act == bal_action_t'(cfg_r[3:0]))
    else $error("short press misclassified");
  a_light_ch1: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && act == ACT_LIGHT_C1 && dual |=> l1_r != $past(l1_r) && $stable(l2_r))
    else $error("channel one light wrong");
  a_chan_dark_single: assert property (@(posedge i_clock) disable iff (i_srst)
    fire && !dual && (act == ACT_DARK_CH1 || act == ACT_DARK_CH2) |=> !dk1_r && !dk2_r)
    else $error("channel capture on single unit");
  a_ready_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
    s_apb_setup |=> pready_r ##1 !pready_r)
    else $error("ready not a single cycle after setup");
  a_write_lands: assert property (@(posedge i_clock) disable iff (i_srst)
    i_psel && i_penable && pready_r && i_pwrite && i_paddr == ADDR_LOCK_SEC
      |=> lsec_r == $past(i_pwdata))
    else $error("lock seconds write lost");

endmodule : bal_button

`default_nettype wire

/* rtl/bal_pkg.sv */
// Package: constants and types for the button action and lock handler
package bal_pkg;

  // ==========================================================================
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;  // Actions, lock mode, dual flag
  localparam logic [7:0] ADDR_LOCK_SEC = 8'h04;  // Auto lock seconds
  localparam logic [7:0] ADDR_SIGSEL   = 8'h08;  // Offset signal selection
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;  // Live state, read only

  // ==========================================================================
  // Config field positions
  localparam int CFG_SHORT_LSB = 0;   // 4 bits
  localparam int CFG_LONG_LSB  = 4;   // 4 bits
  localparam int CFG_LOCK_LSB  = 8;   // 2 bits
  localparam int CFG_DUAL_BIT  = 12;
  localparam int SIG_ALL_BIT   = 31;  // Select all signals
  localparam int SIG_W         = 16;  // Explicit signal list width

  // Status field positions
  localparam int ST_MASTER_LSB = 0;   // 16 bits of mastered signals
  localparam int ST_LIGHT1_BIT = 16;
  localparam int ST_LIGHT2_BIT = 17;
  localparam int ST_LOCKED_BIT = 18;
  localparam int ST_PRESS_BIT  = 19;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
  localparam logic [31:0] LOCK_SEC_RST = 32'h0000_000a;
  localparam logic [31:0] SIGSEL_RST   = 32'h8000_0000;

  // ==========================================================================
  // Action codes
  typedef enum logic [3:0] {
    ACT_NONE     = 4'h0,
    ACT_DARK     = 4'h1,
    ACT_DARK_CH1 = 4'h2,
    ACT_DARK_CH2 = 4'h3,
    ACT_ZO_APPLY = 4'h4,
    ACT_ZO_CLEAR = 4'h5,
    ACT_LIGHT    = 4'h6,
    ACT_LIGHT_C1 = 4'h7,
    ACT_LIGHT_C2 = 4'h8
  } bal_action_t;

  // Lock modes
  localparam logic [1:0] LOCK_NONE   = 2'h0;
  localparam logic [1:0] LOCK_ACTIVE = 2'h1;
  localparam logic [1:0] LOCK_AUTO   = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ        = 200_000_000;
  localparam int SHORT_MAX_MS  = 2000;   // Short press below 2 s
  localparam int LONG_MAX_MS   = 5000;   // Long press up to 5 s
  localparam int TICK_CYC      = CLK_HZ / 1000;   // Cycles per millisecond
  localparam int MS_PER_SEC    = 1000;

  // Press tracker states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_PRESS = 2'b10
  } bal_state_t;

endpackage : bal_pkg
